// ### rtl/csw_top.sv
// clock select and wait control: register, source select and low-power gating
// Function
// RL1 - ignore loop select while loop unstable
// RL2 - clear select on self-clock, stop, loop-wait
// RL3 - bus clock is selected source over two
// RL4 - stop oscillator in stop unless pseudo-stop
// RL5 - system clocks halt in wait if set
// RL6 - timer and watchdog ignore system halt bit
// RL7 - reduced oscillator amplitude in wait if set
// RL8 - loop-wait clears select, powers loop down
// RL9 - software reselects loop after wait itself
// RL10 - loop-wait forces automatic bandwidth on
// RL11 - loop keeps running in wait otherwise
// RL12 - core clock halts in wait if set
// RL13 - timer halts, reinitialises on wait entry
// RL14 - watchdog halts, reinitialises on wait entry
// RL15 - watchdog bit write-once outside special modes
// RL16 - read anytime, write acceptance per bit
// RL17 - lock forced low in self-clock mode
// RL18 - track forced low in self-clock mode
// RL19 - bandwidth automatic, else software acquisition bit
// RL20 - register resets to all zeros
`timescale 1ns/10ps
`include "csw_regs.svh"
module csw_top (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // loop status and special mode pins
    input  wire logic        loop_lock,
    input  wire logic        loop_track,
    input  wire logic        special_mode,
    // same-domain controls
    input  wire logic        self_clock_status,
    input  wire logic        wait_enter,
    input  wire logic        wait_exit,
    input  wire logic        stop_enter,
    input  wire logic        stop_exit,
    input  wire logic        loop_power_on,
    input  wire logic        auto_bw_sw,
    input  wire logic        acq_sw,
    input  wire logic        oscillator_clock_tick,
    input  wire logic        loop_clock_tick,
    // clock outputs
    output logic             loop_clock_select,
    output logic             bus_clock_en,
    output logic             system_clock_run,
    output logic             core_clock_run,
    output logic             timer_run,
    output logic             timer_reinit,
    output logic             watchdog_run,
    output logic             watchdog_reinit,
    // analog controls
    output logic             osc_enable,
    output logic             osc_reduced_amp,
    output logic             loop_powered,
    output logic             auto_bw_eff,
    output logic             loop_high_bw
);
    csw_reg_if rif ();

    csw_ahb_slave u_bus (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .rif       (rif)
    );

    // pin synchronisers
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {special_mode, loop_track, loop_lock};
            sync2_q <= sync1_q;
        end
    end

    wire lock_eff  = sync2_q[0] && !self_clock_status; // RL17
    wire track_eff = sync2_q[1] && !self_clock_status; // RL18
    wire special   = sync2_q[2];

    // register state
    csw_pkg::csw_byte_t sel_q;
    csw_pkg::csw_byte_t sel_d;
    logic               wdg_written_q;
    logic               self_q;
    csw_pkg::csw_mode_t mode_q;
    csw_pkg::csw_mode_t mode_d;

    wire sel_wr   = rif.wr_en && (rif.addr == `CSW_SEL_OFF);
    wire [7:0] wb = rif.wdata[7:0];

    wire loop_wait_bit = sel_q[`CSW_LOOP_WAIT_BIT];
    assign auto_bw_eff = auto_bw_sw || loop_wait_bit; // RL10
    assign loop_high_bw = auto_bw_eff ? !track_eff : acq_sw; // RL19

    wire loop_unstable = auto_bw_eff ? !lock_eff : !track_eff; // RL1
    wire self_enter    = self_clock_status && !self_q;
    wire wait_in       = wait_enter && (mode_q == csw_pkg::CSW_RUN);
    wire stop_in       = stop_enter && (mode_q == csw_pkg::CSW_RUN);
    wire sel_clear     = self_enter || stop_in || (wait_in && loop_wait_bit); // RL2 RL8
    wire wdg_wr_ok     = special || !wdg_written_q; // RL15

    // per-bit write acceptance, hardware clear over software
    always_comb begin
        sel_d = sel_q;
        if (sel_wr) begin
            sel_d[`CSW_OSC_STOP_BIT:`CSW_TMR_WAIT_BIT] =
                wb[`CSW_OSC_STOP_BIT:`CSW_TMR_WAIT_BIT]; // RL16
            if (wdg_wr_ok) begin
                sel_d[`CSW_WDG_WAIT_BIT] = wb[`CSW_WDG_WAIT_BIT]; // RL15
            end
            if (!(wb[`CSW_LOOP_SEL_BIT] && loop_unstable)) begin
                sel_d[`CSW_LOOP_SEL_BIT] = wb[`CSW_LOOP_SEL_BIT]; // RL1
            end
        end
        if (sel_clear) begin
            sel_d[`CSW_LOOP_SEL_BIT] = 1'b0; // RL2
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_q         <= `CSW_SEL_RST; // RL20
            wdg_written_q <= 1'b0;
            self_q        <= 1'b0;
        end else begin
            sel_q         <= sel_d;
            wdg_written_q <= wdg_written_q || sel_wr;
            self_q        <= self_clock_status;
        end
    end

    // power mode tracking
    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            csw_pkg::CSW_RUN: begin
                if (stop_enter) begin
                    mode_d = csw_pkg::CSW_STOP;
                end else if (wait_enter) begin
                    mode_d = csw_pkg::CSW_WAIT;
                end
            end
            csw_pkg::CSW_WAIT: begin
                if (wait_exit) begin
                    mode_d = csw_pkg::CSW_RUN;
                end
            end
            csw_pkg::CSW_STOP: begin
                if (stop_exit) begin
                    mode_d = csw_pkg::CSW_RUN;
                end
            end
            default: begin
                mode_d = csw_pkg::CSW_RUN;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= csw_pkg::CSW_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    wire in_wait = (mode_q == csw_pkg::CSW_WAIT);
    wire in_stop = (mode_q == csw_pkg::CSW_STOP);

    // source select and bus clock divider
    assign loop_clock_select = sel_q[`CSW_LOOP_SEL_BIT];
    wire src_tick = loop_clock_select ? loop_clock_tick : oscillator_clock_tick; // RL3
    logic bus_pulse;
    csw_clk_div #(
        .DIV (`CSW_BUS_DIV)
    ) u_bus_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clr     (sel_clear),
        .tick    (src_tick),
        .pulse   (bus_pulse)
    );

    // wait and stop gating
    assign system_clock_run = !in_stop && !(in_wait && sel_q[`CSW_SYS_WAIT_BIT]); // RL5
    assign bus_clock_en     = bus_pulse && system_clock_run; // RL3
    assign core_clock_run   = !in_stop && !(in_wait && sel_q[`CSW_CORE_WAIT_BIT]); // RL12
    assign timer_run        = !in_stop && !(in_wait && sel_q[`CSW_TMR_WAIT_BIT]); // RL13 RL6
    assign watchdog_run     = !in_stop && !(in_wait && sel_q[`CSW_WDG_WAIT_BIT]); // RL14 RL6
    assign timer_reinit     = wait_in && sel_q[`CSW_TMR_WAIT_BIT]; // RL13
    assign watchdog_reinit  = wait_in && sel_q[`CSW_WDG_WAIT_BIT]; // RL14
    assign osc_enable       = !(in_stop && !sel_q[`CSW_OSC_STOP_BIT]); // RL4
    assign osc_reduced_amp  = (in_stop && sel_q[`CSW_OSC_STOP_BIT])
                            || (in_wait && sel_q[`CSW_RED_AMP_BIT]); // RL4 RL7
    assign loop_powered     = (loop_power_on || self_clock_status)
                            && !(in_wait && loop_wait_bit) && !in_stop; // RL8 RL11

    // read mux, readable at any time
    logic [31:0] stat_word;
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[`CSW_ST_LOCK_BIT]  = lock_eff;
        stat_word[`CSW_ST_TRACK_BIT] = track_eff;
        stat_word[`CSW_ST_SELF_BIT]  = self_clock_status;
        stat_word[`CSW_ST_AUTO_BIT]  = auto_bw_eff;
        stat_word[`CSW_ST_HIBW_BIT]  = loop_high_bw;
        stat_word[`CSW_ST_MODE_LSB +: $bits(csw_pkg::csw_mode_t)] = mode_q;
        stat_word[`CSW_ST_WDGW_BIT]  = wdg_written_q;
        stat_word[`CSW_ST_LOOPP_BIT] = loop_powered;
    end

    // read decode, shows a write still in its data phase
    wire hit_sel  = rif.rd_en && (rif.raddr == `CSW_SEL_OFF);
    wire hit_stat = rif.rd_en && (rif.raddr == `CSW_STAT_OFF);
    assign rif.rdata = hit_sel  ? {24'h000000, sel_d} : // RL16
                       hit_stat ? stat_word : 32'h0000_0000;
endmodule

// ### rtl/csw_regs.svh
// register offsets, bit positions and reset values of the clock select block
`ifndef CSW_REGS_SVH
`define CSW_REGS_SVH

`define CSW_ADDR_W        12
`define CSW_SEL_OFF       12'h000
`define CSW_STAT_OFF      12'h004

`define CSW_SEL_RST       8'h00

`define CSW_LOOP_SEL_BIT  7
`define CSW_OSC_STOP_BIT  6
`define CSW_SYS_WAIT_BIT  5
`define CSW_RED_AMP_BIT   4
`define CSW_LOOP_WAIT_BIT 3
`define CSW_CORE_WAIT_BIT 2
`define CSW_TMR_WAIT_BIT  1
`define CSW_WDG_WAIT_BIT  0

`define CSW_ST_LOCK_BIT   0
`define CSW_ST_TRACK_BIT  1
`define CSW_ST_SELF_BIT   2
`define CSW_ST_AUTO_BIT   3
`define CSW_ST_HIBW_BIT   4
`define CSW_ST_MODE_LSB   5
`define CSW_ST_WDGW_BIT   7
`define CSW_ST_LOOPP_BIT  8

`define CSW_BUS_DIV       2

`endif

// ### rtl/csw_pkg.sv
// types shared by the clock select block
package csw_pkg;
    typedef enum logic [1:0] {
        CSW_RUN  = 2'b00,
        CSW_WAIT = 2'b01,
        CSW_STOP = 2'b10
    } csw_mode_t;

    typedef logic [7:0] csw_byte_t;
endpackage

// ### rtl/csw_reg_if.sv
// register access carrier between bus slave and core
`timescale 1ns/10ps
interface csw_reg_if;
    logic        wr_en;
    logic        rd_en;
    logic [11:0] addr;
    logic [11:0] raddr;
    logic [31:0] wdata;
    logic [31:0] rdata;

    modport slave (output wr_en, output rd_en, output addr, output raddr, output wdata,
                   input rdata);
    modport core  (input wr_en, input rd_en, input addr, input raddr, input wdata,
                   output rdata);
endinterface

// ### rtl/csw_clk_div.sv
// enable divider: one output pulse every DIV input ticks
`timescale 1ns/10ps
module csw_clk_div #(
    parameter int DIV = 2
) (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // ticks
    input  wire logic clr,
    input  wire logic tick,
    output logic      pulse
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    wire           wrap = tick && (cnt_q == LAST);

    assign cnt_d = clr ? '0 : (wrap ? '0 : (tick ? cnt_q + CW'(1) : cnt_q));
    assign pulse = wrap && !clr;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// ### rtl/csw_ahb_slave.sv
// ahb-lite slave front end, zero wait states, always okay
`timescale 1ns/10ps
module csw_ahb_slave (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // core side
    csw_reg_if.slave         rif
);
    logic        wr_pend_q;
    logic [11:0] addr_q;
    logic [31:0] hrdata_q;

    wire take   = hsel && hready && htrans[1];
    wire word   = (hsize == 3'h2) && (haddr[1:0] == 2'h0);
    wire take_w = take && hwrite && word;
    wire take_r = take && !hwrite;

    assign rif.wr_en = wr_pend_q;
    assign rif.addr  = addr_q;
    assign rif.raddr = haddr[11:0];
    assign rif.rd_en = take_r;
    assign rif.wdata = hwdata;
    assign hrdata    = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q    <= 12'h000;
        end else begin
            wr_pend_q <= take_w;
            addr_q    <= take ? haddr[11:0] : addr_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (take_r) begin
            hrdata_q <= rif.rdata;
        end
    end
endmodule

// ### tb/csw_properties.sv
// property checker for the clock select block
`timescale 1ns/10ps
module csw_properties (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // status and mode inputs
    input wire logic loop_lock,
    input wire logic loop_track,
    input wire logic self_clock_status,
    input wire logic wait_enter,
    input wire logic stop_enter,
    input wire logic auto_bw_sw,
    input wire logic acq_sw,
    // watched outputs
    input wire logic loop_clock_select,
    input wire logic system_clock_run,
    input wire logic core_clock_run,
    input wire logic timer_run,
    input wire logic timer_reinit,
    input wire logic watchdog_run,
    input wire logic watchdog_reinit,
    input wire logic osc_enable,
    input wire logic auto_bw_eff,
    input wire logic loop_high_bw
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_sel_unstable: assert property ((!loop_lock && !loop_track)[*4] |=> !$rose(loop_clock_select))
        else $error("select rose with loop unstable");
    a_self_no_sel: assert property (self_clock_status[*2] |-> !loop_clock_select)
        else $error("select set in self-clock");
    a_stop_clear: assert property (stop_enter |=> !loop_clock_select)
        else $error("select kept after stop entry");
    a_osc_off: assert property ($fell(osc_enable) |-> $past(stop_enter))
        else $error("oscillator off without stop");
    a_sys_halt: assert property ($fell(system_clock_run) |-> $past(wait_enter | stop_enter))
        else $error("system clocks halted outside entry");
    a_core_halt: assert property ($fell(core_clock_run) |-> $past(wait_enter | stop_enter))
        else $error("core clock halted outside entry");
    a_tmr_reinit: assert property (timer_reinit |-> wait_enter ##1 !timer_run)
        else $error("timer reinit without wait halt");
    a_wdg_reinit: assert property (watchdog_reinit |-> wait_enter ##1 !watchdog_run)
        else $error("watchdog reinit without wait halt");
    a_auto_sw: assert property (auto_bw_sw |-> auto_bw_eff)
        else $error("automatic bandwidth not followed");
    a_acq_manual: assert property (!auto_bw_eff |-> loop_high_bw == acq_sw)
        else $error("manual bandwidth not followed");

    c_wait: cover property (wait_enter ##1 !timer_run);
    c_sel: cover property ($rose(loop_clock_select));
    c_stop: cover property (stop_enter ##1 !osc_enable);
endmodule

bind csw_top csw_properties csw_properties_i (.*);

// ### tb/tb_top.sv
// self-checking bench of the clock select block
`timescale 1ns/10ps
module tb_top;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_ph;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        loop_lock, loop_track, special_mode, self_clock_status, loop_power_on;
    logic        wait_enter, wait_exit, stop_enter, stop_exit, auto_bw_sw, acq_sw;
    logic        oscillator_clock_tick, loop_clock_tick, loop_clock_select, bus_clock_en;
    logic        system_clock_run, core_clock_run, timer_run, timer_reinit, watchdog_run;
    logic        watchdog_reinit, osc_enable, osc_reduced_amp, loop_powered, auto_bw_eff;
    logic        loop_high_bw;
    logic [7:0]  r;
    logic [31:0] exp_q[$];
    int          n_fail, cmp_count, npulse;

    assign hready = hreadyout;
    csw_top csw_top_i (.*);
    always #50 hclk = ~hclk;

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task report_and_stop;
        if (n_fail == 0 && cmp_count > 0 && exp_q.size() == 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // bounded wait for hready at a rising edge
    task rdy;
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge hclk);
            if (hready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            report_and_stop();
        end
    endtask

    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= w;
        hsize <= 3'b010;
        rdy();
        htrans <= 2'b00;
        hwdata <= d;
        rdy();
    endtask

    task wr(input logic [11:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d});
    endtask

    task rd(input logic [11:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b0, a, 32'h0);
    endtask

    task enter(input logic stop);
        @(posedge hclk);
        if (stop) stop_enter <= 1'b1;
        else wait_enter <= 1'b1;
        @(negedge hclk);
    endtask

    task leave;
        @(posedge hclk);
        wait_enter <= 1'b0;
        stop_enter <= 1'b0;
        @(negedge hclk);
    endtask

    task quit;
        @(posedge hclk);
        wait_exit <= 1'b1;
        stop_exit <= 1'b1;
        @(posedge hclk);
        wait_exit <= 1'b0;
        stop_exit <= 1'b0;
    endtask

    // read results checked against the oldest note
    always @(posedge hclk) begin
        if (rd_ph && hready && exp_q.size() > 0) begin
            chk("hrdata", exp_q.pop_front(), hrdata);
            chk("hresp", 32'h0, {31'h0, hresp});
        end
        rd_ph <= hsel && htrans == 2'b10 && !hwrite && hready;
        if (bus_clock_en === 1'b1) npulse++;
    end

    initial begin
        {hclk, hresetn, hsel, hwrite, rd_ph, haddr, hwdata, htrans, hsize} = '0;
        {loop_lock, loop_track, special_mode, self_clock_status, wait_enter} = '0;
        {wait_exit, stop_enter, stop_exit, auto_bw_sw, acq_sw} = '0;
        {oscillator_clock_tick, loop_clock_tick} = '0;
        loop_power_on = 1'b0;
        {n_fail, cmp_count, npulse} = '0;
        r = 8'h5c;
        cyc(10);
        hresetn <= 1'b1;
        rd(12'h000, 8'h00);
        rd(12'h010, 8'h00);
        wr(12'h000, 8'h01);
        wr(12'h000, 8'h00);
        rd(12'h000, 8'h01);
        repeat (3) begin
            r = lfsr(r);
            wr(12'h000, r & 8'h7e);
            rd(12'h000, (r & 8'h7e) | 8'h01);
        end
        special_mode <= 1'b1;
        cyc(4);
        wr(12'h000, 8'h00);
        rd(12'h000, 8'h00);
        auto_bw_sw <= 1'b1;
        cyc(4);
        wr(12'h000, 8'h80);
        rd(12'h000, 8'h00);
        auto_bw_sw <= 1'b0;
        loop_track <= 1'b1;
        acq_sw <= 1'b1;
        cyc(4);
        wr(12'h000, 8'h80);
        rd(12'h000, 8'h80);
        @(negedge hclk);
        chk("high bw", 32'h1, {31'h0, loop_high_bw});
        rd(12'h004, 8'h92);
        @(posedge hclk);
        loop_lock <= 1'b1;
        loop_power_on <= 1'b1;
        wr(12'h000, 8'h8e);
        rd(12'h000, 8'h8e);
        enter(1'b0);
        chk("timer reinit", 32'h1, {31'h0, timer_reinit});
        leave();
        chk("wait a", 32'h0d, {25'h0, loop_clock_select, core_clock_run, timer_run,
            system_clock_run, watchdog_run, loop_powered, auto_bw_eff});
        quit();
        rd(12'h000, 8'h0e);
        wr(12'h000, 8'hb1);
        enter(1'b0);
        chk("wdg reinit", 32'h1, {31'h0, watchdog_reinit});
        leave();
        chk("wait b", 32'h2b, {26'h0, loop_clock_select, system_clock_run, timer_run,
            watchdog_run, loop_powered, osc_reduced_amp});
        quit();
        wr(12'h000, 8'hc0);
        enter(1'b1);
        leave();
        chk("stop a", 32'h1, {30'h0, loop_clock_select, osc_enable});
        quit();
        wr(12'h000, 8'h80);
        enter(1'b1);
        leave();
        chk("stop b", 32'h0, {30'h0, loop_clock_select, osc_enable});
        quit();
        wr(12'h000, 8'h80);
        self_clock_status <= 1'b1;
        cyc(4);
        wr(12'h000, 8'h80);
        rd(12'h000, 8'h00);
        self_clock_status <= 1'b0;
        cyc(4);
        npulse = 0;
        oscillator_clock_tick <= 1'b1;
        cyc(20);
        oscillator_clock_tick <= 1'b0;
        cyc(2);
        chk("osc pulses", 32'd10, npulse);
        wr(12'h000, 8'h80);
        npulse = 0;
        loop_clock_tick <= 1'b1;
        cyc(20);
        loop_clock_tick <= 1'b0;
        cyc(2);
        chk("loop pulses", 32'd10, npulse);
        report_and_stop();
    end
endmodule
